/* File: rtl/exec_pkg.sv */
package exec_pkg;
    // Opcodes
    localparam logic [7:0] OP_CARRY_SET = 8'hdf;
    localparam logic [7:0] OP_ASR_R = 8'hd0;
    localparam logic [7:0] OP_ASR_IR = 8'hd1;
    localparam logic [7:0] OP_STOP = 8'h7f;
    localparam logic [7:0] OP_SUB_RR = 8'h22;
    localparam logic [7:0] OP_SUB_RIR = 8'h23;
    localparam logic [7:0] OP_SUB_R_R = 8'h24;
    localparam logic [7:0] OP_SUB_R_IR = 8'h25;
    localparam logic [7:0] OP_SUB_R_IM = 8'h26;
    // Cycle counts
    localparam logic [2:0] CYC_4 = 3'h4;
    localparam logic [2:0] CYC_6 = 3'h6;
    // Byte counts
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    // Flag bit positions
    localparam int FL_C = 7;
    localparam int FL_Z = 6;
    localparam int FL_S = 5;
    localparam int FL_V = 4;
    localparam int FL_D = 3;
    localparam int FL_H = 2;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [2:0] CNT_ZERO = 3'h0;

    // AXI4-Lite register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;   // [0] start (write 1)
    localparam logic [7:0] ADDR_INSTR = 8'h04;  // [7:0] opcode
    localparam logic [7:0] ADDR_DST = 8'h08;    // [7:0] destination operand
    localparam logic [7:0] ADDR_SRC = 8'h0c;    // [7:0] source operand
    localparam logic [7:0] ADDR_FLAGS = 8'h10;  // [7:0] flag register
    localparam logic [7:0] ADDR_RESULT = 8'h14; // [7:0] result
    localparam logic [7:0] ADDR_STATUS = 8'h18; // [0] busy [1] stop [2] illegal [5:4] bytes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_STOP = 3'b100
    } exec_state_t;

    typedef struct packed {
        logic [7:0] result;
        logic [7:0] flags;
        logic wr_dst;
        logic stop;
        logic legal;
        logic [2:0] cycles;
        logic [1:0] bytes;
    } alu_out_t;
endpackage : exec_pkg

/* File: rtl/exec_unit.sv */
// Function
// - Carry-set forces C, one byte, four cycles
// - Carry-set leaves Z S V D H
// - Shift right keeps bit 7, copies to 6
// - Shifted-out LSB goes into carry
// - Shift sets Z,S, clears V, keeps D,H
// - Stop halts clocks, enters stop mode
// - Stop mode retains all register contents
// - External reset or interrupt ends stop
// - Stop changes no flag
// - Subtract writes dst minus src back
// - Subtract adds two's complement of source
// - Subtract leaves source location unchanged
// - Subtract C borrow, Z zero, S negative
// - Subtract V from opposite-sign overflow rule
// - Subtract always sets decimal-adjust flag
// - Subtract H clear on low-nibble carry
`timescale 1ns/1ps
`default_nettype none
module exec_unit
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ext_int,
    output logic clk_run,
    output logic [7:0] flags_out,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import exec_pkg::*;

    // ==================================================
    // State
    exec_state_t state_r, state_nxt;
    logic [7:0] instr_r, instr_nxt;
    logic [7:0] dst_r, dst_nxt;
    logic [7:0] src_r, src_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic [7:0] result_r, result_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic illegal_r, illegal_nxt;
    logic [1:0] len_r, len_nxt;
    logic [31:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic aw_have_r, aw_have_nxt;
    logic w_have_r, w_have_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    alu_out_t alu;

    // ==================================================
    // Datapath
    // Pure function of latched opcode, operands and flags; committed at the end
    always_comb begin
        logic [8:0] sum;
        logic [4:0] lo;
        logic [7:0] shifted;
        sum = 9'h000;
        lo = 5'h00;
        shifted = 8'h00;
        alu.result = dst_r;
        alu.flags = flags_r;
        alu.wr_dst = 1'b0;
        alu.stop = 1'b0;
        alu.legal = 1'b1;
        alu.cycles = CYC_4;
        alu.bytes = LEN_2;
        case (instr_r)
            OP_CARRY_SET: begin
                alu.flags[FL_C] = 1'b1;
                alu.bytes = LEN_1;
            end
            OP_ASR_R, OP_ASR_IR: begin
                shifted = {dst_r[7], dst_r[7:1]};
                alu.result = shifted;
                alu.wr_dst = 1'b1;
                alu.flags[FL_C] = dst_r[0];
                alu.flags[FL_Z] = (shifted == BYTE_ZERO);
                alu.flags[FL_S] = shifted[7];
                alu.flags[FL_V] = 1'b0;
            end
            OP_STOP: begin
                alu.stop = 1'b1;
                alu.bytes = LEN_1;
            end
            OP_SUB_RR, OP_SUB_RIR, OP_SUB_R_R, OP_SUB_R_IR, OP_SUB_R_IM: begin
                sum = {1'b0, dst_r} + {1'b0, ~src_r} + 9'h001;
                lo = {1'b0, dst_r[3:0]} + {1'b0, ~src_r[3:0]} + 5'h01;
                // result back to destination; source never written
                alu.result = sum[7:0];
                alu.wr_dst = 1'b1;
                alu.flags[FL_C] = ~sum[8];
                alu.flags[FL_Z] = (sum[7:0] == BYTE_ZERO);
                alu.flags[FL_S] = sum[7];
                alu.flags[FL_V] = (dst_r[7] ^ src_r[7]) & (sum[7] == src_r[7]);
                alu.flags[FL_D] = 1'b1;
                alu.flags[FL_H] = ~lo[4];
                alu.cycles = (instr_r == OP_SUB_RR) ? CYC_4 : CYC_6;
                alu.bytes = (instr_r == OP_SUB_RR || instr_r == OP_SUB_RIR) ? LEN_2 : LEN_3;
            end
            default: begin
                alu.legal = 1'b0;
            end
        endcase
    end

    // ==================================================
    // Bus write path
    logic wr_fire, rd_fire, start;
    logic [7:0] wr_sel;
    always_comb begin
        s_axi_awready = ~aw_have_r & ~bvalid_r;
        s_axi_wready = ~w_have_r & ~bvalid_r;
        awaddr_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_r;
        wdata_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_r;
        wstrb_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_r;
        aw_have_nxt = aw_have_r | (s_axi_awvalid & s_axi_awready);
        w_have_nxt = w_have_r | (s_axi_wvalid & s_axi_wready);
        wr_fire = aw_have_r & w_have_r & ~bvalid_r;
        wr_sel = awaddr_r[7:0];
        if (wr_fire) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
        end
        bvalid_nxt = wr_fire | (bvalid_r & ~s_axi_bready);
        bresp_nxt = bresp_r;
        if (wr_fire) begin
            bresp_nxt = (wr_sel == ADDR_CTRL || wr_sel == ADDR_INSTR || wr_sel == ADDR_DST ||
                         wr_sel == ADDR_SRC || wr_sel == ADDR_FLAGS) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ==================================================
    // Execution sequencer
    // Bus writes to operand and flag registers are dropped while busy or stopped; the commit updates dst and flags
    always_comb begin
        state_nxt = state_r;
        instr_nxt = instr_r;
        dst_nxt = dst_r;
        src_nxt = src_r;
        flags_nxt = flags_r;
        result_nxt = result_r;
        cnt_nxt = cnt_r;
        illegal_nxt = illegal_r;
        len_nxt = len_r;
        start = wr_fire && wr_sel == ADDR_CTRL && wstrb_r[0] && wdata_r[0];
        case (state_r)
            ST_IDLE: begin
                if (wr_fire && wstrb_r[0]) begin
                    if (wr_sel == ADDR_INSTR) instr_nxt = wdata_r[7:0];
                    if (wr_sel == ADDR_DST) dst_nxt = wdata_r[7:0];
                    if (wr_sel == ADDR_SRC) src_nxt = wdata_r[7:0];
                    if (wr_sel == ADDR_FLAGS) flags_nxt = wdata_r[7:0];
                end
                if (start) begin
                    illegal_nxt = ~alu.legal;
                    len_nxt = alu.bytes;
                    if (alu.legal) begin
                        cnt_nxt = alu.cycles - CNT_ONE;
                        state_nxt = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                cnt_nxt = cnt_r - CNT_ONE;
                if (cnt_r == CNT_ONE) begin
                    // flags and result commit in one edge
                    flags_nxt = alu.flags;
                    result_nxt = alu.result;
                    if (alu.wr_dst) dst_nxt = alu.result;
                    state_nxt = alu.stop ? ST_STOP : ST_IDLE;
                end
            end
            ST_STOP: begin
                if (ext_int) state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // ==================================================
    // Bus read path
    always_comb begin
        s_axi_arready = ~rvalid_r;
        rd_fire = s_axi_arvalid & s_axi_arready;
        rvalid_nxt = rd_fire | (rvalid_r & ~s_axi_rready);
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rd_fire) begin
            rresp_nxt = RESP_OKAY;
            case (s_axi_araddr[7:0])
                ADDR_CTRL: rdata_nxt = 32'h0000_0000;
                ADDR_INSTR: rdata_nxt = {24'h000000, instr_r};
                ADDR_DST: rdata_nxt = {24'h000000, dst_r};
                ADDR_SRC: rdata_nxt = {24'h000000, src_r};
                ADDR_FLAGS: rdata_nxt = {24'h000000, flags_r};
                ADDR_RESULT: rdata_nxt = {24'h000000, result_r};
                ADDR_STATUS: rdata_nxt = {26'h0000000, len_r, 1'b0, illegal_r,
                                          state_r == ST_STOP, state_r == ST_EXEC};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    // ==================================================
    // Registers
    // external reset also releases stop; relies on reset being held long enough
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            instr_r <= BYTE_ZERO;
            dst_r <= BYTE_ZERO;
            src_r <= BYTE_ZERO;
            flags_r <= FLAGS_RST;
            result_r <= BYTE_ZERO;
            cnt_r <= CNT_ZERO;
            illegal_r <= 1'b0;
            len_r <= 2'h0;
            awaddr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else begin
            state_r <= state_nxt;
            instr_r <= instr_nxt;
            dst_r <= dst_nxt;
            src_r <= src_nxt;
            flags_r <= flags_nxt;
            result_r <= result_nxt;
            cnt_r <= cnt_nxt;
            illegal_r <= illegal_nxt;
            len_r <= len_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // Outputs
    // clocks gated off in stop mode
    assign clk_run = (state_r != ST_STOP);
    assign flags_out = flags_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule : exec_unit
`default_nettype wire

/* File: tb/exec_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus handshake and stop-mode checks
module exec_unit_monitor
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ext_int,
    input wire logic clk_run,
    input wire logic [7:0] flags_out,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    chk_wake_int: assert property (!clk_run && ext_int |-> ##[1:2] clk_run)
        else $error("stop mode kept after interrupt");
    chk_stop_hold: assert property (!clk_run && !ext_int |=> !clk_run && $stable(flags_out))
        else $error("stop mode state disturbed");
    chk_reset_exit: assert property ($fell(sys_rst) |-> clk_run && flags_out == FLAGS_RST)
        else $error("clocks or flags wrong after reset");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h1c
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    chk_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule : exec_unit_monitor
bind exec_unit exec_unit_monitor mon (.clk(clk), .sys_rst(sys_rst), .ext_int(ext_int), .clk_run(clk_run),
    .flags_out(flags_out), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

/* File: tb/fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Fetch and decode side, reaching the core over the register bus
module fetch_model (
    input wire logic clk,
    output logic [31:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [31:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // Released payload is inverted so a stale value is never mistaken for a live one
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : fetch_model
`default_nettype wire

/* File: tb/carry_shift_subtract_stop_ops_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Instruction tests through the register bus
module carry_shift_subtract_stop_ops_tb;
    import exec_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ext_int = 1'b0;
    logic clk_run, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] flags_out;
    logic [31:0] awaddr, wdata, araddr, rdata, rv;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] e;
    logic [7:0] dv [5] = '{8'h12, 8'h21, 8'h21, 8'h05, 8'h80};
    logic [7:0] sv [5] = '{8'h03, 8'h90, 8'h65, 8'h05, 8'h01};
    int err_count = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    exec_unit uut (.clk(clk), .sys_rst(sys_rst), .ext_int(ext_int), .clk_run(clk_run), .flags_out(flags_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    fetch_model bus (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        bus.wr({24'h0, a}, {24'h0, d}, rs);
        cmp({32'h0, rs}, {32'h0, RESP_OKAY});
    endtask : put
    task automatic get(input logic [7:0] a, input logic [7:0] x);
        bus.rd({24'h0, a}, rv, rs);
        cmp({rs, rv}, {RESP_OKAY, 24'h0, x});
    endtask : get
    // Load operands, start, check busy at a fixed cycle, then poll busy under a bound
    task automatic run(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s, input logic [7:0] f);
        logic six;
        six = (op == OP_SUB_RIR) || (op == OP_SUB_R_R) || (op == OP_SUB_R_IR) || (op == OP_SUB_R_IM);
        put(ADDR_FLAGS, f);
        put(ADDR_DST, d);
        put(ADDR_SRC, s);
        put(ADDR_INSTR, op);
        put(ADDR_CTRL, 8'h01);
        // One idle edge lands this read after a four-cycle op ends but before a six-cycle one does
        @(posedge clk);
        bus.rd({24'h0, ADDR_STATUS}, rv, rs);
        cmp({33'h0, rv[0]}, {33'h0, six});
        for (int i = 0; i < 20 && rv[0] !== 1'b0; i++) begin
            bus.rd({24'h0, ADDR_STATUS}, rv, rs);
        end
        // Busy still set when the bound runs out counts as a hang
        cmp({33'h0, rv[0]}, 34'h0);
    endtask : run
    task automatic wait_run(input logic v);
        for (int i = 0; i < 50 && clk_run !== v; i++) begin
            @(posedge clk);
        end
        cmp({33'h0, clk_run}, {33'h0, v});
    endtask : wait_run
    // Borrow means src above dst; half borrow is the same test on the low nibbles
    function automatic logic [15:0] sub_exp(input logic [7:0] d, input logic [7:0] s);
        logic [7:0] r;
        r = d - s;
        return {r, s > d, r == 8'h00, r[7], d[7] != s[7] && r[7] == s[7], 1'b1, s[3:0] > d[3:0], 2'b00};
    endfunction : sub_exp
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        get(ADDR_FLAGS, 8'h00);
        run(OP_CARRY_SET, 8'h00, 8'h00, 8'h7c);
        get(ADDR_FLAGS, 8'hfc);
        get(ADDR_STATUS, 8'h10);
        $display("carry set done");
        run(OP_ASR_R, 8'h9a, 8'h00, 8'h9c);
        get(ADDR_RESULT, 8'hcd);
        get(ADDR_FLAGS, 8'h2c);
        get(ADDR_STATUS, 8'h20);
        run(OP_ASR_IR, 8'h01, 8'h00, 8'h00);
        get(ADDR_DST, 8'h00);
        get(ADDR_FLAGS, 8'hc0);
        $display("shift done");
        for (int k = 0; k < 5; k++) begin
            run(OP_SUB_RR + 8'(k), dv[k], sv[k], 8'h00);
            e = sub_exp(dv[k], sv[k]);
            get(ADDR_DST, e[15:8]);
            get(ADDR_FLAGS, e[7:0]);
            get(ADDR_SRC, sv[k]);
            get(ADDR_STATUS, k < 2 ? 8'h20 : 8'h30);
        end
        $display("subtract done");
        run(8'h00, 8'h00, 8'h00, 8'h00);
        cmp({33'h0, rv[2]}, 34'h1);
        bus.rd(32'h20, rv, rs);
        cmp({rs, rv}, {RESP_SLVERR, 32'h0});
        bus.wr({24'h0, ADDR_RESULT}, 32'h0, rs);
        cmp({32'h0, rs}, {32'h0, RESP_SLVERR});
        $display("refusals done");
        run(OP_STOP, 8'h5a, 8'h00, 8'h54);
        wait_run(1'b0);
        repeat (8) @(posedge clk);
        cmp({25'h0, clk_run, flags_out}, {25'h0, 1'b0, 8'h54});
        ext_int <= 1'b1;
        @(posedge clk);
        ext_int <= 1'b0;
        wait_run(1'b1);
        get(ADDR_FLAGS, 8'h54);
        get(ADDR_DST, 8'h5a);
        put(ADDR_CTRL, 8'h01);
        wait_run(1'b0);
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        wait_run(1'b1);
        $display("stop done");
        give_verdict();
    end
    // Whole run needs a few hundred cycles
    initial begin
        #100us;
        err_count++;
        give_verdict();
    end
endmodule : carry_shift_subtract_stop_ops_tb
`default_nettype wire
